/* design/lbmbf_ctrl.sv */
/*
  Control core of the lighting power block: AXI4-Lite register file,
  bank mapping, pattern setup, PWM duty scaling, thermal shutdown, short
  fault flags and boost frequency/feedback control.
  Assumes all inputs synchronous to aclk; measured PWM duty arrives as a
  9-bit fraction with 9'h100 meaning 100 percent.
*/
`timescale 1ns/1ps
module lbmbf_ctrl
  import lbmbf_pkg::*;
(
  // Clock, reset and hardware enable
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic hardware_enable_pin,
  // AXI4-Lite write channels
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  // AXI4-Lite read channels
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  // Analog side indications
  input wire logic temp_over_hi,
  input wire logic temp_recovered,
  input wire logic [2:0] hv_short_detect,
  input wire logic [23:0] hv_sink_headroom,
  input wire logic [8:0] pwm_duty,
  // Power stage controls
  output logic boost_enable,
  output logic charge_pump_enable,
  output logic sinks_enable,
  output logic boost_freq_1mhz,
  output logic boost_raise,
  // High-voltage bank outputs
  output logic [2:0] hv_sink_bank_b,
  output logic [2:0] hv_feedback_enable,
  output logic [4:0] hv_bank_a_full_scale,
  output logic [4:0] hv_bank_b_full_scale,
  output logic [10:0] hv_bank_a_level,
  output logic [10:0] hv_bank_b_level,
  // Low-voltage bank outputs
  output logic [17:0] lv_sink_bank,
  output logic [95:0] lv_bank_ramp,
  output logic [5:0] lv_pattern_enable,
  output logic [191:0] lv_bank_pattern
);

  // ***************************************************************
  // State
  // ***************************************************************
  typedef struct packed {
    logic awready, wready, bvalid, arready, rvalid;
    logic [7:0] awaddr;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic [1:0] bresp, rresp;
    logic [31:0] rdata;
    logic [2:0] map_b, fb_en;
    logic pwm_a, pwm_b, lv_split_low, lv_split_high;
    logic [5:0] pat_en;
    logic [4:0] fs_a, fs_b;
    logic [2:0] lsb_a, lsb_b;
    logic [7:0] msb_a, msb_b;
    logic [10:0] code_a, code_b;
    logic freq_sel, auto_en;
    logic [7:0] auto_thr, headroom;
    logic [15:0] ramp_ce, ramp_fh;
    logic [7:0] rf_ce, rf_fh;
    logic [5:0][31:0] pat;
    logic [2:0] short_flag;
    logic thermal_off, out_on, freq_1mhz, raise;
    logic [10:0] level_a, level_b;
    logic [5:0][2:0] lv_bank;
    logic [5:0][15:0] lv_ramp;
    logic live;
  } lbmbf_state_type;

  localparam lbmbf_state_type STATE_RESET = '{awready: 1'b1,
    wready: 1'b1, arready: 1'b1, fb_en: RST_FB, fs_a: RST_FS,
    fs_b: RST_FS, auto_thr: RST_AUTO_THR, headroom: RST_HEADROOM,
    default: '0};

  lbmbf_state_type s;
  lbmbf_state_type next_state;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [7:0] pat_off;
  logic [31:0] mask;
  logic [32:0] rd_w;
  logic [32:0] rr;
  logic [31:0] nw;
  logic [2:0] clr;
  logic wr_fire;
  logic [8:0] duty;
  logic [19:0] prod_a;
  logic [19:0] prod_b;
  logic [5:0][2:0] lv_bank_w;
  logic [5:0][15:0] lv_ramp_w;

  lbmbf_boost_if bif ();

  // ***************************************************************
  // Register readback, also the base of partial-strobe writes
  // ***************************************************************
  function automatic logic [32:0] read_word(input lbmbf_state_type st,
                                            input logic [7:0] a);
    logic [32:0] r;
    logic [7:0] off;
    r = {1'b1, 32'h0000_0000};
    off = a - ADDR_PAT0;
    case (a)
      ADDR_HV_CFG: r[7:0] = {st.pwm_b, st.pwm_a, st.fb_en, st.map_b};
      ADDR_LV_CFG: r[7:0] = {st.pat_en, st.lv_split_high, st.lv_split_low};
      ADDR_FS_A: r[4:0] = st.fs_a;
      ADDR_LSB_A: r[2:0] = st.lsb_a;
      ADDR_MSB_A: r[7:0] = st.msb_a;
      ADDR_FS_B: r[4:0] = st.fs_b;
      ADDR_LSB_B: r[2:0] = st.lsb_b;
      ADDR_MSB_B: r[7:0] = st.msb_b;
      ADDR_BOOST: r[3:0] = {st.auto_en, 2'h0, st.freq_sel};
      ADDR_AUTO_THR: r[7:0] = st.auto_thr;
      ADDR_RAMP_CE: r[15:0] = st.ramp_ce;
      ADDR_RAMP_FH: r[15:0] = st.ramp_fh;
      ADDR_RF_CE: r[7:0] = st.rf_ce;
      ADDR_RF_FH: r[7:0] = st.rf_fh;
      ADDR_STATUS: r[4:0] = {st.freq_1mhz, st.short_flag, st.thermal_off};
      ADDR_HEADROOM: r[7:0] = st.headroom;
      default: begin
        if (a >= ADDR_PAT0 && a < ADDR_PAT_END) begin
          r[31:0] = st.pat[off[4:2]];
        end else begin
          r[32] = 1'b0;
        end
      end
    endcase
    return r;
  endfunction : read_word

  // ***************************************************************
  // Per-bank low-voltage mapping and ramp source
  // ***************************************************************
  for (genvar i = 0; i < 6; i++) begin : g_bank
    localparam bit UPPER = (i >= 3);
    // Split groups give each sink its own bank, else the group head
    assign lv_bank_w[i] = (UPPER ? s.lv_split_high : s.lv_split_low) ?
      3'(i) : (UPPER ? BANK_F : BANK_C);
    // Pattern banks take the shared rise/fall, others the group ramp
    assign lv_ramp_w[i] = s.pat_en[i] ?
      {8'h00, (UPPER ? s.rf_fh : s.rf_ce)} :
      (UPPER ? s.ramp_fh : s.ramp_ce);
  end

  // ***************************************************************
  // Boost helpers
  // ***************************************************************
  assign bif.msb_a = s.msb_a;
  assign bif.msb_b = s.msb_b;
  assign bif.active_a = ~&s.map_b;
  assign bif.active_b = |s.map_b;
  assign bif.fixed_1mhz = s.freq_sel;
  assign bif.auto_en = s.auto_en;
  assign bif.threshold = s.auto_thr;
  assign bif.fb_en = s.fb_en;
  assign bif.headroom = hv_sink_headroom;

  lbmbf_freq_select lbmbf_freq_select_i (.bif(bif.freq));
  lbmbf_headroom_select lbmbf_headroom_select_i (.bif(bif.head));

  // ***************************************************************
  // Next state
  // ***************************************************************
  always_comb begin
    next_state = s;
    wa = {s.awaddr[7:2], 2'b00};
    ra = {araddr[7:2], 2'b00};
    pat_off = wa - ADDR_PAT0;
    mask = {{8{s.wstrb[3]}}, {8{s.wstrb[2]}}, {8{s.wstrb[1]}},
            {8{s.wstrb[0]}}};
    rd_w = read_word(s, wa);
    nw = (rd_w[31:0] & ~mask) | (s.wdata & mask);
    clr = 3'h0;
    rr = read_word(s, ra);
    // Address and data are taken in either order, then held
    if (awvalid && s.awready) begin
      next_state.awready = 1'b0;
      next_state.awaddr = awaddr;
    end
    if (wvalid && s.wready) begin
      next_state.wready = 1'b0;
      next_state.wdata = wdata;
      next_state.wstrb = wstrb;
    end
    wr_fire = !s.awready && !s.wready && !s.bvalid;
    if (wr_fire) begin
      next_state.bvalid = 1'b1;
      next_state.bresp = rd_w[32] ? RESP_OKAY : RESP_SLVERR;
      case (wa)
        ADDR_HV_CFG: begin
          next_state.map_b = nw[HV_MAP_LSB +: 3];
          next_state.fb_en = nw[HV_FB_LSB +: 3];
          next_state.pwm_a = nw[HV_PWM_A_BIT];
          next_state.pwm_b = nw[HV_PWM_B_BIT];
        end
        ADDR_LV_CFG: begin
          next_state.lv_split_low = nw[LV_SPLIT_LOW_BIT];
          next_state.lv_split_high = nw[LV_SPLIT_HIGH_BIT];
          next_state.pat_en = nw[LV_PAT_EN_LSB +: 6];
        end
        ADDR_FS_A: next_state.fs_a = nw[4:0];
        ADDR_FS_B: next_state.fs_b = nw[4:0];
        // Low byte only parks; current is untouched until the high byte
        ADDR_LSB_A: next_state.lsb_a = nw[2:0];
        ADDR_LSB_B: next_state.lsb_b = nw[2:0];
        ADDR_MSB_A: begin
          next_state.msb_a = nw[7:0];
          next_state.code_a = {nw[7:0], s.lsb_a};
        end
        ADDR_MSB_B: begin
          next_state.msb_b = nw[7:0];
          next_state.code_b = {nw[7:0], s.lsb_b};
        end
        ADDR_BOOST: begin
          next_state.freq_sel = nw[BOOST_FREQ_BIT];
          next_state.auto_en = nw[BOOST_AUTO_BIT];
        end
        ADDR_AUTO_THR: next_state.auto_thr = nw[7:0];
        ADDR_RAMP_CE: next_state.ramp_ce = nw[15:0];
        ADDR_RAMP_FH: next_state.ramp_fh = nw[15:0];
        ADDR_RF_CE: next_state.rf_ce = nw[7:0];
        ADDR_RF_FH: next_state.rf_fh = nw[7:0];
        ADDR_STATUS: clr = nw[STAT_SHORT_LSB +: 3] & mask[STAT_SHORT_LSB +: 3]
                           & s.wdata[STAT_SHORT_LSB +: 3];
        ADDR_HEADROOM: next_state.headroom = nw[7:0];
        default: begin
          if (rd_w[32]) begin
            next_state.pat[pat_off[4:2]] = nw;
          end
        end
      endcase
    end
    if (s.bvalid && bready) begin
      next_state.bvalid = 1'b0;
      next_state.awready = 1'b1;
      next_state.wready = 1'b1;
    end
    // One read at a time, answered the cycle after the address
    if (arvalid && s.arready) begin
      next_state.arready = 1'b0;
      next_state.rvalid = 1'b1;
      next_state.rdata = rr[31:0];
      next_state.rresp = rr[32] ? RESP_OKAY : RESP_SLVERR;
    end
    if (s.rvalid && rready) begin
      next_state.rvalid = 1'b0;
      next_state.arready = 1'b1;
    end
    // Hysteresis: trip at the high indication, release at recovery
    if (temp_over_hi) begin
      next_state.thermal_off = 1'b1;
    end else if (temp_recovered) begin
      next_state.thermal_off = 1'b0;
    end
    next_state.out_on = !next_state.thermal_off;
    // A new fault beats a clear in the same cycle
    next_state.short_flag = (s.short_flag & ~clr) |
                            (hv_short_detect & s.fb_en);
    // Duty above one would overdrive, so it saturates
    duty = (pwm_duty > DUTY_ONE) ? DUTY_ONE : pwm_duty;
    prod_a = {9'h000, s.code_a} * {11'h000, duty};
    prod_b = {9'h000, s.code_b} * {11'h000, duty};
    next_state.level_a = s.pwm_a ? prod_a[18:8] : s.code_a;
    next_state.level_b = s.pwm_b ? prod_b[18:8] : s.code_b;
    next_state.freq_1mhz = bif.freq_1mhz;
    next_state.raise = bif.any_fb &&
                       (bif.min_headroom < s.headroom);
    next_state.lv_bank = lv_bank_w;
    next_state.lv_ramp = lv_ramp_w;
    // Low only in the cycle that reset reloads the state
    next_state.live = 1'b1;
  end

  // Enable pin low holds the whole block at defaults
  always_ff @(posedge aclk) begin
    if (!aresetn || !hardware_enable_pin) begin
      s <= STATE_RESET;
    end else begin
      s <= next_state;
    end
  end

  // ***************************************************************
  // Outputs
  // ***************************************************************
  assign awready = s.awready;
  assign wready = s.wready;
  assign bresp = s.bresp;
  assign bvalid = s.bvalid;
  assign arready = s.arready;
  assign rdata = s.rdata;
  assign rresp = s.rresp;
  assign rvalid = s.rvalid;
  assign boost_enable = s.out_on;
  assign charge_pump_enable = s.out_on;
  assign sinks_enable = s.out_on;
  assign boost_freq_1mhz = s.freq_1mhz;
  assign boost_raise = s.raise;
  assign hv_sink_bank_b = s.map_b;
  assign hv_feedback_enable = s.fb_en;
  assign hv_bank_a_full_scale = s.fs_a;
  assign hv_bank_b_full_scale = s.fs_b;
  assign hv_bank_a_level = s.level_a;
  assign hv_bank_b_level = s.level_b;
  assign lv_sink_bank = s.lv_bank;
  assign lv_bank_ramp = s.lv_ramp;
  assign lv_pattern_enable = s.pat_en;
  assign lv_bank_pattern = s.pat;

  // ***************************************************************
  // Assertions
  // ***************************************************************
  default clocking cb @(posedge aclk);
  endclocking
  // The release edge still reloads defaults, so checks wait one more cycle
  default disable iff (!aresetn || !hardware_enable_pin || !s.live);

  thermal_trip_a: assert property (
    temp_over_hi |=> !boost_enable && !charge_pump_enable && !sinks_enable)
    else $error("outputs still on after over-temperature");
  thermal_hold_a: assert property (
    s.thermal_off && !temp_recovered |=> !sinks_enable)
    else $error("sinks re-enabled before recovery");
  short_mask_a: assert property (
    !s.short_flag[0] && !(hv_short_detect[0] && s.fb_en[0])
    |=> !s.short_flag[0])
    else $error("short flag set for excluded sink");
  short_set_a: assert property (
    (hv_short_detect & s.fb_en) != 3'h0
    |=> (s.short_flag & $past(hv_short_detect & s.fb_en)) ==
        $past(hv_short_detect & s.fb_en))
    else $error("short flag lost");
  level_nopwm_a: assert property (
    !s.pwm_a |=> hv_bank_a_level == $past(s.code_a))
    else $error("bank A level not code with pwm off");
  level_pwm_a: assert property (
    s.pwm_b && pwm_duty == 9'h000 |=> hv_bank_b_level == 11'h000)
    else $error("bank B level not scaled by zero duty");
  lsb_hold_a: assert property (
    wr_fire && wa == ADDR_LSB_A |=> s.code_a == $past(s.code_a))
    else $error("low byte write changed brightness code");
  msb_load_a: assert property (
    wr_fire && wa == ADDR_MSB_A && s.wstrb[0]
    |=> s.code_a == {$past(s.wdata[7:0]), $past(s.lsb_a)})
    else $error("high byte write did not load code");
  auto_freq_a: assert property (
    s.auto_en && s.map_b == 3'h0 && s.msb_a > s.auto_thr
    |=> boost_freq_1mhz)
    else $error("auto mode did not pick 1 MHz");
  fixed_freq_a: assert property (
    !s.auto_en |=> boost_freq_1mhz == $past(s.freq_sel))
    else $error("fixed frequency not followed");
  lv_low_map_a: assert property (
    !s.lv_split_low |=> lv_sink_bank[8:0] == {BANK_C, BANK_C, BANK_C})
    else $error("sinks one to three not on bank C");
  lv_high_map_a: assert property (
    s.lv_split_high |=> lv_sink_bank[17:9] == {BANK_H, BANK_G, BANK_F})
    else $error("sinks four to six not split");
  no_feedback_a: assert property (
    s.fb_en == 3'h0 |=> !boost_raise)
    else $error("boost raised with no fed-back sink");

  cov_auto_up: cover property (s.auto_en ##1 boost_freq_1mhz);
  cov_thermal: cover property (temp_over_hi ##1 !sinks_enable
    ##[1:20] sinks_enable);
  cov_msb_write: cover property (wr_fire && wa == ADDR_MSB_A);
  cov_short: cover property (s.short_flag != 3'h0);

endmodule : lbmbf_ctrl

/* design/lbmbf_freq_select.sv */
/*
  Boost switching frequency choice: fixed select bit, or automatic by
  brightness against a threshold. Purely combinational; the caller
  registers the result.
*/
`timescale 1ns/1ps
module lbmbf_freq_select (
  // Carrier to the control core
  lbmbf_boost_if.freq bif
);

  logic [7:0] larger;

  // ***************************************************************
  // Frequency decision
  // ***************************************************************
  // Larger brightness of the banks that drive any sink
  always_comb begin
    larger = 8'h00;
    if (bif.active_a) begin
      larger = bif.msb_a;
    end
    if (bif.active_b && (bif.msb_b > larger)) begin
      larger = bif.msb_b;
    end
    if (bif.auto_en) begin
      bif.freq_1mhz = larger > bif.threshold;
    end else begin
      bif.freq_1mhz = bif.fixed_1mhz;
    end
  end

endmodule : lbmbf_freq_select

/* design/lbmbf_headroom_select.sv */
/*
  Picks the string that needs the highest boost voltage, i.e. the lowest
  measured headroom among sinks kept in the feedback loop.
  Assumes headroom codes are unsigned, lower meaning less margin.
*/
`timescale 1ns/1ps
module lbmbf_headroom_select (
  // Carrier to the control core
  lbmbf_boost_if.head bif
);

  logic [2:0][7:0] cand;

  // ***************************************************************
  // Per-sink candidates
  // ***************************************************************
  // Excluded sinks park at full scale so they never win
  for (genvar k = 0; k < 3; k++) begin : g_sink
    assign cand[k] = bif.fb_en[k] ? bif.headroom[k] : 8'hff;
  end

  // Lowest candidate wins the regulation loop
  always_comb begin
    bif.min_headroom = cand[0];
    if (cand[1] < bif.min_headroom) begin
      bif.min_headroom = cand[1];
    end
    if (cand[2] < bif.min_headroom) begin
      bif.min_headroom = cand[2];
    end
    bif.any_fb = |bif.fb_en;
  end

endmodule : lbmbf_headroom_select

/* pkg/lbmbf_boost_if.sv */
/*
  Carrier between the control core and its boost helpers: brightness,
  mode bits and sink measurements go out, frequency and headroom come back.
  Assumes all parties sit in the aclk domain.
*/
`timescale 1ns/1ps
interface lbmbf_boost_if;
  logic [7:0] msb_a;
  logic [7:0] msb_b;
  logic active_a;
  logic active_b;
  logic fixed_1mhz;
  logic auto_en;
  logic [7:0] threshold;
  logic freq_1mhz;
  logic [2:0] fb_en;
  logic [2:0][7:0] headroom;
  logic [7:0] min_headroom;
  logic any_fb;

  modport ctrl (output msb_a, msb_b, active_a, active_b, fixed_1mhz,
                auto_en, threshold, fb_en, headroom,
                input freq_1mhz, min_headroom, any_fb);
  modport freq (input msb_a, msb_b, active_a, active_b, fixed_1mhz,
                auto_en, threshold, output freq_1mhz);
  modport head (input fb_en, headroom, output min_headroom, any_fb);
endinterface : lbmbf_boost_if

/* pkg/lbmbf_pkg.sv */
/*
  Constants shared by the bank mapping and boost frequency control block:
  register byte addresses, field positions, reset values and encodings.
  Assumes a 32-bit AXI4-Lite register bus with an 8-bit byte address.
*/
package lbmbf_pkg;

  // ***************************************************************
  // Register byte addresses (one aligned 32-bit word each)
  // ***************************************************************
  localparam logic [7:0] ADDR_HV_CFG = 8'h00;
  localparam logic [7:0] ADDR_LV_CFG = 8'h04;
  localparam logic [7:0] ADDR_FS_A = 8'h08;
  localparam logic [7:0] ADDR_LSB_A = 8'h0c;
  localparam logic [7:0] ADDR_MSB_A = 8'h10;
  localparam logic [7:0] ADDR_FS_B = 8'h14;
  localparam logic [7:0] ADDR_LSB_B = 8'h18;
  localparam logic [7:0] ADDR_MSB_B = 8'h1c;
  localparam logic [7:0] ADDR_BOOST = 8'h20;
  localparam logic [7:0] ADDR_AUTO_THR = 8'h24;
  localparam logic [7:0] ADDR_RAMP_CE = 8'h28;
  localparam logic [7:0] ADDR_RAMP_FH = 8'h2c;
  localparam logic [7:0] ADDR_RF_CE = 8'h30;
  localparam logic [7:0] ADDR_RF_FH = 8'h34;
  localparam logic [7:0] ADDR_STATUS = 8'h38;
  localparam logic [7:0] ADDR_HEADROOM = 8'h3c;
  localparam logic [7:0] ADDR_PAT0 = 8'h40;
  localparam logic [7:0] ADDR_PAT_END = 8'h58;

  // ***************************************************************
  // Field positions
  // ***************************************************************
  localparam int HV_MAP_LSB = 0;
  localparam int HV_FB_LSB = 3;
  localparam int HV_PWM_A_BIT = 6;
  localparam int HV_PWM_B_BIT = 7;
  localparam int LV_SPLIT_LOW_BIT = 0;
  localparam int LV_SPLIT_HIGH_BIT = 1;
  localparam int LV_PAT_EN_LSB = 2;
  localparam int BOOST_FREQ_BIT = 0;
  localparam int BOOST_AUTO_BIT = 3;
  localparam int STAT_THERMAL_BIT = 0;
  localparam int STAT_SHORT_LSB = 1;
  localparam int STAT_FREQ_BIT = 4;

  // ***************************************************************
  // Reset values and encodings
  // ***************************************************************
  localparam logic [2:0] RST_FB = 3'h7;
  localparam logic [4:0] RST_FS = 5'h00;
  localparam logic [7:0] RST_AUTO_THR = 8'h6c;
  localparam logic [7:0] RST_HEADROOM = 8'h20;
  localparam logic [8:0] DUTY_ONE = 9'h100;
  localparam logic [2:0] BANK_C = 3'h0;
  localparam logic [2:0] BANK_D = 3'h1;
  localparam logic [2:0] BANK_E = 3'h2;
  localparam logic [2:0] BANK_F = 3'h3;
  localparam logic [2:0] BANK_G = 3'h4;
  localparam logic [2:0] BANK_H = 3'h5;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage : lbmbf_pkg

/* sim/lbmbf_host_model.sv */
/*
  Host side partner: an AXI4-Lite master with one write and one read task.
  Assumes each task is entered right after a rising aclk edge.
*/
`timescale 1ns/1ps
module lbmbf_host_model (
  // Clock and write channels
  input wire logic aclk,
  output logic [7:0] awaddr = '0,
  output logic awvalid = 1'b0,
  input wire logic awready,
  output logic [31:0] wdata = '0,
  output logic [3:0] wstrb = '0,
  output logic wvalid = 1'b0,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  output logic bready = 1'b0,
  // Read channels
  output logic [7:0] araddr = '0,
  output logic arvalid = 1'b0,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  output logic rready = 1'b0
);
  // ***************************************************************
  // Bus tasks
  // ***************************************************************
  // Both write channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    awaddr <= a;
    wdata <= d;
    wstrb <= 4'hf;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
  endtask : wr
  // Data and response taken at the edge that shows rvalid
  task automatic rd(input logic [7:0] a, output logic [31:0] d,
                    output logic [1:0] r);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : lbmbf_host_model

/* sim/tb_led_bank_map_boost_freq_ctrl.sv */
/*
  Self-checking bench of the bank mapping and boost frequency block.
  Assumes the host model owns the register bus; the bench is the analog side.
*/
`timescale 1ns/1ps
module tb_led_bank_map_boost_freq_ctrl
  import lbmbf_pkg::*;
;
  logic aclk, aresetn, hardware_enable_pin, temp_over_hi, temp_recovered;
  logic [7:0] awaddr, araddr;
  logic awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready;
  logic [31:0] wdata, rdata, rd_word;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, rd_resp;
  logic [2:0] hv_short_detect, hv_sink_bank_b, hv_feedback_enable;
  logic [23:0] hv_sink_headroom;
  logic [8:0] pwm_duty;
  logic boost_enable, charge_pump_enable, sinks_enable;
  logic boost_freq_1mhz, boost_raise;
  logic [4:0] hv_bank_a_full_scale, hv_bank_b_full_scale;
  logic [10:0] hv_bank_a_level, hv_bank_b_level;
  logic [17:0] lv_sink_bank;
  logic [95:0] lv_bank_ramp;
  logic [5:0] lv_pattern_enable;
  logic [191:0] lv_bank_pattern;
  int failures = 0;
  int compares = 0;
  // ***************************************************************
  // Instances and helper tasks
  // ***************************************************************
  lbmbf_ctrl lbmbf_ctrl_i (.*);
  lbmbf_host_model lbmbf_host_model_i (.*);
  // Count each comparison, report a mismatch at once
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : cmp
  // Outputs lag their causes, so give them three edges
  task automatic tick;
    repeat (3) @(posedge aclk);
  endtask : tick
  task automatic w(input logic [7:0] a, input logic [31:0] d);
    lbmbf_host_model_i.wr(a, d);
    tick();
  endtask : w
  // Read into rd_word and rd_resp; an edge passes so rready is not reused
  task automatic r(input logic [7:0] a);
    lbmbf_host_model_i.rd(a, rd_word, rd_resp);
    @(posedge aclk);
  endtask : r
  task automatic conclude;
    $display("compares %0d failures %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : conclude
  // Clock at 40 MHz and a watchdog well beyond the test length
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  initial begin
    repeat (3000) @(posedge aclk);
    failures++;
    conclude();
  end
  // Main sequence
  initial begin
    {aresetn, temp_over_hi, temp_recovered, hv_short_detect} <= '0;
    hardware_enable_pin <= 1'b1;
    hv_sink_headroom <= {8'h05, 8'h40, 8'h40};
    pwm_duty <= 9'h080;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    tick();
    cmp(hv_feedback_enable, RST_FB);
    cmp(lv_sink_bank, 18'h1b600);
    w(ADDR_HV_CFG, 32'h1d);
    w(ADDR_LV_CFG, 32'h7);
    w(ADDR_RAMP_CE, 32'h1234);
    w(ADDR_RF_CE, 32'h5a);
    w(ADDR_PAT0 + 8'h04, 32'hdeadbeef);
    cmp({hv_sink_bank_b, hv_feedback_enable}, 6'h2b);
    cmp(lv_sink_bank, 18'h2c688);
    cmp(lv_bank_ramp[31:0], 32'h1234005a);
    cmp(lv_bank_pattern[63:32], 32'hdeadbeef);
    cmp(boost_raise, 1'b0);
    hv_sink_headroom[7:0] <= 8'h10;
    hv_short_detect <= 3'h7;
    tick();
    cmp(boost_raise, 1'b1);
    r(ADDR_STATUS);
    cmp(rd_word & 32'he, 32'h6);
    w(ADDR_FS_A, 32'h1f);
    w(ADDR_LSB_A, 32'h5);
    cmp(hv_bank_a_level, 11'h0);
    w(ADDR_MSB_A, 32'h80);
    cmp({hv_bank_a_full_scale, hv_bank_a_level},
        16'hfc05);
    w(ADDR_HV_CFG, 32'h5d);
    cmp(hv_bank_a_level, 11'h202);
    w(ADDR_BOOST, 32'h1);
    cmp(boost_freq_1mhz, 1'b1);
    // Threshold for a three-string, large-inductor setup
    w(ADDR_AUTO_THR, 32'h7c);
    w(ADDR_MSB_A, 32'h7c);
    w(ADDR_BOOST, 32'h9);
    cmp(boost_freq_1mhz, 1'b0);
    w(ADDR_MSB_B, 32'h90);
    cmp(boost_freq_1mhz, 1'b1);
    w(ADDR_HV_CFG, 32'hd8);
    cmp({boost_freq_1mhz, hv_bank_b_level}, 12'h240);
    w(ADDR_MSB_A, 32'h7d);
    cmp(boost_freq_1mhz, 1'b1);
    pwm_duty <= 9'h000;
    tick();
    cmp({hv_bank_a_level, hv_bank_b_level}, 22'h0);
    w(ADDR_HV_CFG, 32'hc0);
    cmp({hv_feedback_enable, boost_raise}, 4'h0);
    w(ADDR_STATUS, 32'h2);
    r(ADDR_STATUS);
    cmp(rd_word & 32'he, 32'h4);
    temp_over_hi <= 1'b1;
    tick();
    cmp({boost_enable, charge_pump_enable, sinks_enable}, 3'h0);
    temp_over_hi <= 1'b0;
    tick();
    cmp(sinks_enable, 1'b0);
    temp_recovered <= 1'b1;
    tick();
    cmp({boost_enable, charge_pump_enable, sinks_enable}, 3'h7);
    hardware_enable_pin <= 1'b0;
    tick();
    cmp({sinks_enable, hv_feedback_enable}, 4'h7);
    hardware_enable_pin <= 1'b1;
    tick();
    r(ADDR_AUTO_THR);
    cmp(rd_word & 32'hff, RST_AUTO_THR);
    r(8'hfc);
    cmp(rd_word, 32'h0);
    cmp(rd_resp, RESP_SLVERR);
    conclude();
  end
endmodule : tb_led_bank_map_boost_freq_ctrl
